//--- rtl/dmcp_control_port.sv
// mode register file with four-wire and two-wire control front ends
`default_nettype none

// Summary of operation
// - select pin low: four-wire, high: two-wire
// - four-wire port runs on its bit clock
// - each transaction is one 16-bit word
// - next seven bits are register index
// - low byte is write or read data
// - read data driven after eighth pulse
// - write lands only after sixteenth pulse
// - serial out changes on falling edges
// - two-wire mode: slave, standard and fast
// - two-wire mode reassigns the four pins
// - upper five address bits fixed 10011
// - two low address bits from strap pins
// - answer only on own address match
// - never acts as bus master
// - multi-byte write index increments, no ack past last
// - no acknowledge for undefined register write
// - first read after write repeats index
module dmcp_control_port
  import dmcp_pkg::*;
(
  input  wire logic                   clk,             // system clock
  input  wire logic                   reset,           // async, high
  input  wire logic                   portTypeSelect,  // low four-wire
  input  wire logic                   ctrlSelectN,     // select / strap lo
  input  wire logic                   ctrlSerialIn,    // data / strap hi
  input  wire logic                   ctrlBitClock,    // bit clock / scl
  input  wire logic                   ctrlSerialOutIn, // sda level seen
  output logic                        ctrlSerialOut,   // data / sda value
  output logic                        ctrlSerialOutEn, // output enable
  output logic [REG_COUNT*8-1:0]      modeRegs         // register contents
);

  // ****************************************
  // helper functions
  // ****************************************
  // true for indexes backed by storage
  function automatic logic isDef(input logic [6:0] idx);
    isDef = (idx >= REG_FIRST) &&
            (idx < REG_FIRST + 7'(REG_COUNT));
  endfunction

  // storage slot of an index
  function automatic logic [SLOT_W-1:0] slotOf(input logic [6:0] idx);
    logic [6:0] d;
    d = idx - REG_FIRST;
    slotOf = d[SLOT_W-1:0];
  endfunction

  // undefined indexes read back as zero
  function automatic logic [7:0] regRead(input dmcp_regs_t regs,
                                         input logic [6:0] idx);
    regRead = isDef(idx) ? regs[slotOf(idx)] : 8'h00;
  endfunction

  // ****************************************
  // state types of the three clock regions
  // ****************************************
  typedef struct packed {
    logic [4:0]  cnt;  // rising edges this frame
    logic [15:0] sh;   // incoming command word
  } dmcp_rise_s;

  typedef struct packed {
    logic        tog;  // flips once per write word
    logic [14:0] word; // index and data of that write
  } dmcp_hold_s;

  typedef struct packed {
    logic [7:0] outSh;  // readback shifter
  } dmcp_fall_s;

  typedef struct packed {
    logic        sclM, sclS, sclD;   // scl sync, delayed copy
    logic        sdaM, sdaS, sdaD;   // sda sync, delayed copy
    logic        modeM, modeS;       // front end select sync
    logic [1:0]  adrM, adrS;         // address strap sync
    logic        togM, togS, togD;   // write toggle sync
    dmcp_i2c_e   st;                 // two-wire slave state
    logic [3:0]  bitCnt;             // bits of current byte
    logic [7:0]  sh;                 // received byte
    logic [6:0]  idx;                // register index
    logic        incPend;            // index bump owed
    logic        rw;                 // direction of transfer
    logic        oe;                 // pulling sda low
    dmcp_regs_t  regs;               // mode registers
  } dmcp_sys_s;

  dmcp_rise_s rq, rn;  // bit clock rising region
  dmcp_hold_s hq, hn;  // write word handed to clk
  dmcp_fall_s fq, fn;  // bit clock falling region
  dmcp_sys_s  q, n;    // system clock region

  // ****************************************
  // four-wire port: rising edge region
  // ****************************************
  // select high clears the frame, so each word starts fresh; a write
  // word stays in the hold register until the next write completes
  always_comb begin
    rn = rq;
    hn = hq;
    if (rq.cnt != WORD_BITS) begin
      rn.sh  = {rq.sh[14:0], ctrlSerialIn};
      rn.cnt = rq.cnt + 5'h01;
      // last pulse of a write word hands it over
      if (rq.cnt == WORD_BITS - 5'h01 && !rq.sh[RW_POS-1]) begin
        hn.word = {rq.sh[13:0], ctrlSerialIn};
        hn.tog  = ~hq.tog;
      end
    end
  end

  // frame state, reset by the select going high
  always_ff @(posedge ctrlBitClock or posedge ctrlSelectN) begin
    if (ctrlSelectN) begin
      rq <= '0;
    end else begin
      rq <= rn;
    end
  end

  // handed-over word survives the select going high
  always_ff @(posedge ctrlBitClock or posedge reset) begin
    if (reset) begin
      hq <= '0;
    end else begin
      hq <= hn;
    end
  end

  // ****************************************
  // four-wire port: falling edge region
  // ****************************************
  logic [7:0] rdByte;  // register selected by the frame index

  // registers change only after a write handshake, so they are quiet
  // while a read frame samples them; a read racing its own write to
  // the same index may see either value
  assign rdByte = regRead(q.regs, rq.sh[6:0]);

  always_comb begin
    fn = fq;
    if (rq.cnt == HALF_BITS && rq.sh[DATA_MSB]) begin
      fn.outSh = rdByte;
    end else begin
      fn.outSh = {fq.outSh[6:0], 1'b0};
    end
  end

  always_ff @(negedge ctrlBitClock or posedge ctrlSelectN) begin
    if (ctrlSelectN) begin
      fq <= '0;
    end else begin
      fq <= fn;
    end
  end

  // ****************************************
  // system clock region
  // ****************************************
  logic       sclRise, sclFall;  // filtered scl edges
  logic       startC, stopC;     // bus conditions
  logic [6:0] myAddr;            // own slave address
  logic [6:0] wIdx;              // target of a data byte
  logic [7:0] txByte;            // byte being sent
  logic [7:0] nxByte;            // byte after the current
  logic       wrPulse;           // four-wire write arrived

  assign sclRise = q.sclS & ~q.sclD;
  assign sclFall = ~q.sclS & q.sclD;
  assign startC  = q.sclS & q.sclD & q.sdaD & ~q.sdaS;
  assign stopC   = q.sclS & q.sclD & ~q.sdaD & q.sdaS;
  assign myAddr  = {ADDR_PREFIX, q.adrS};
  assign wIdx    = q.idx + {6'h00, q.incPend};
  assign txByte  = regRead(q.regs, q.idx);
  assign nxByte  = regRead(q.regs, q.idx + 7'h01);
  assign wrPulse = q.togS ^ q.togD;

  always_comb begin
    n = q;
    // pins pass two flops before use
    n.sclM  = ctrlBitClock;
    n.sclS  = q.sclM;
    n.sclD  = q.sclS;
    n.sdaM  = ctrlSerialOutIn;
    n.sdaS  = q.sdaM;
    n.sdaD  = q.sdaS;
    n.modeM = portTypeSelect;
    n.modeS = q.modeM;
    n.adrM  = {ctrlSerialIn, ctrlSelectN};
    n.adrS  = q.adrM;
    n.togM  = hq.tog;
    n.togS  = q.togM;
    n.togD  = q.togS;
    if (!q.modeS) begin
      // four-wire mode holds the slave idle
      n.st = I2C_IDLE;
      n.oe = 1'b0;
    end else if (startC) begin
      n.st     = I2C_ADDR;
      n.bitCnt = 4'h0;
      n.oe     = 1'b0;
    end else if (stopC) begin
      n.st = I2C_IDLE;
      n.oe = 1'b0;
    end else if (sclRise) begin
      case (q.st)
        I2C_ADDR, I2C_INDEX, I2C_WDATA: begin
          n.sh     = {q.sh[6:0], q.sdaS};
          n.bitCnt = q.bitCnt + 4'h1;
        end
        I2C_RDATA: begin
          n.bitCnt = q.bitCnt + 4'h1;
        end
        I2C_RACK: begin
          // master refusal ends the read
          if (q.sdaS) begin
            n.st = I2C_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (sclFall) begin
      case (q.st)
        I2C_ADDR: begin
          if (q.bitCnt == BYTE_BITS) begin
            if (q.sh[7:1] == myAddr) begin
              n.oe = 1'b1;
              n.rw = q.sh[0];
              n.st = I2C_AACK;
            end else begin
              n.st = I2C_IDLE;
            end
          end
        end
        I2C_INDEX: begin
          if (q.bitCnt == BYTE_BITS) begin
            n.idx     = q.sh[6:0];
            n.incPend = 1'b0;
            n.oe      = 1'b1;
            n.st      = I2C_WACK;
          end
        end
        I2C_WDATA: begin
          if (q.bitCnt == BYTE_BITS) begin
            if (isDef(wIdx)) begin
              n.regs[slotOf(wIdx)] = q.sh;
              n.idx     = wIdx;
              n.incPend = 1'b1;
              n.oe      = 1'b1;
              n.st      = I2C_WACK;
            end else begin
              n.st = I2C_IDLE;
            end
          end
        end
        I2C_AACK: begin
          n.bitCnt = 4'h0;
          if (q.rw) begin
            // index kept: a read after a write repeats it
            n.incPend = 1'b0;
            n.oe      = ~txByte[7];
            n.st      = I2C_RDATA;
          end else begin
            n.oe = 1'b0;
            n.st = I2C_INDEX;
          end
        end
        I2C_WACK: begin
          n.oe     = 1'b0;
          n.bitCnt = 4'h0;
          n.st     = I2C_WDATA;
        end
        I2C_RDATA: begin
          if (q.bitCnt == BYTE_BITS) begin
            n.oe = 1'b0;
            n.st = I2C_RACK;
          end else begin
            n.oe = ~txByte[~q.bitCnt[2:0]];
          end
        end
        I2C_RACK: begin
          n.idx    = q.idx + 7'h01;
          n.bitCnt = 4'h0;
          n.oe     = ~nxByte[7];
          n.st     = I2C_RDATA;
        end
        default: begin
          n.st = I2C_IDLE;
        end
      endcase
    end
    // four-wire write lands once its word is complete
    if (wrPulse && !q.modeS && isDef(hq.word[6+IDX_LSB:IDX_LSB])) begin
      n.regs[slotOf(hq.word[6+IDX_LSB:IDX_LSB])] =
        hq.word[DATA_MSB:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q      <= '0;
      q.st   <= I2C_IDLE;
      q.regs <= {REG_COUNT{REG_RESET}};
    end else begin
      q <= n;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // two-wire data is open drain: value low, enable pulls
  assign ctrlSerialOut   = q.modeS ? 1'b0 : fq.outSh[7];
  assign ctrlSerialOutEn = q.modeS ? q.oe : 1'b1;
  assign modeRegs        = q.regs;

  // ****************************************
  // assertions
  // ****************************************
  sequence s_addrEnd;
    sclFall && q.modeS && q.st == I2C_ADDR && q.bitCnt == BYTE_BITS;
  endsequence

  sequence s_loadRead;
    rq.cnt == HALF_BITS && rq.sh[DATA_MSB];
  endsequence

  property p_modeSel;
    @(posedge clk) disable iff (reset)
    !q.modeS |-> ctrlSerialOutEn ##1 (q.st == I2C_IDLE && !q.oe);
  endproperty
  a_modeSel: assert property (p_modeSel)
    else $error("slave active in four-wire mode");

  property p_addrMiss;
    @(posedge clk) disable iff (reset)
    s_addrEnd ##0 (q.sh[7:1] != myAddr) |=> q.st == I2C_IDLE && !q.oe;
  endproperty
  a_addrMiss: assert property (p_addrMiss)
    else $error("foreign address answered");

  property p_addrHit;
    @(posedge clk) disable iff (reset)
    s_addrEnd ##0 (q.sh[7:1] == {ADDR_PREFIX, q.adrS})
      |=> q.oe && q.st == I2C_AACK;
  endproperty
  a_addrHit: assert property (p_addrHit)
    else $error("own address not acknowledged");

  property p_wrInc;
    @(posedge clk) disable iff (reset)
    (sclFall && q.modeS && q.st == I2C_WDATA && q.bitCnt == BYTE_BITS
      && isDef(wIdx)) |=> q.idx == $past(wIdx) && q.incPend && q.oe;
  endproperty
  a_wrInc: assert property (p_wrInc)
    else $error("write index not advanced");

  property p_nackUndef;
    @(posedge clk) disable iff (reset)
    (sclFall && q.modeS && q.st == I2C_WDATA && q.bitCnt == BYTE_BITS
      && !isDef(wIdx)) |=> !q.oe [*2];
  endproperty
  a_nackUndef: assert property (p_nackUndef)
    else $error("undefined register acknowledged");

  property p_firstRead;
    @(posedge clk) disable iff (reset)
    (sclFall && q.modeS && q.st == I2C_AACK && q.rw)
      |=> q.idx == $past(q.idx) && q.st == I2C_RDATA;
  endproperty
  a_firstRead: assert property (p_firstRead)
    else $error("read index moved before first byte");

  property p_slaveOnly;
    @(posedge clk) disable iff (reset)
    q.oe |-> q.st inside {I2C_AACK, I2C_WACK, I2C_RDATA};
  endproperty
  a_slaveOnly: assert property (p_slaveOnly)
    else $error("sda driven outside slave phases");

  property p_spiCommit;
    @(posedge clk) disable iff (reset)
    (wrPulse && !q.modeS && isDef(hq.word[6+IDX_LSB:IDX_LSB]))
      |=> regRead(q.regs, $past(hq.word[6+IDX_LSB:IDX_LSB]))
          == $past(hq.word[DATA_MSB:0]);
  endproperty
  a_spiCommit: assert property (p_spiCommit)
    else $error("four-wire write not stored");

  property p_wordLen;
    @(posedge ctrlBitClock) disable iff (ctrlSelectN)
    rq.cnt == WORD_BITS |=> rq.cnt == WORD_BITS && rq.sh == $past(rq.sh);
  endproperty
  a_wordLen: assert property (p_wordLen)
    else $error("frame went past sixteen bits");

  property p_readOut;
    @(negedge ctrlBitClock) disable iff (ctrlSelectN)
    s_loadRead |=> fq.outSh == $past(rdByte)
      ##1 fq.outSh[7] == $past(fq.outSh[6]);
  endproperty
  a_readOut: assert property (p_readOut)
    else $error("readback byte not shifted out");

endmodule
`default_nettype wire

//--- rtl/dmcp_pkg.sv
// constants and types shared by the mode control port
`default_nettype none
package dmcp_pkg;
  // ****************************************
  // command word layout (four-wire port)
  // ****************************************
  localparam logic [4:0] WORD_BITS = 5'h10;  // pulses per command word
  localparam logic [4:0] HALF_BITS = 5'h08;  // direction plus index
  localparam int         RW_POS    = 15;     // direction flag position
  localparam int         IDX_MSB   = 14;     // register index msb
  localparam int         IDX_LSB   = 8;      // register index lsb
  localparam int         DATA_MSB  = 7;      // data msb

  // ****************************************
  // two-wire slave address and register map
  // ****************************************
  localparam logic [4:0] ADDR_PREFIX = 5'h13;  // fixed upper bits 10011
  localparam logic [6:0] REG_FIRST   = 7'h10;  // first defined index
  localparam int         REG_COUNT   = 8;      // defined registers
  localparam int         SLOT_W      = 3;      // slot index width
  localparam logic [7:0] REG_RESET   = 8'h00;  // value after reset
  localparam logic [3:0] BYTE_BITS   = 4'h8;   // bits per bus byte

  typedef logic [REG_COUNT-1:0][7:0] dmcp_regs_t;  // register storage

  // two-wire slave states
  typedef enum logic [3:0] {
    I2C_IDLE,   // waiting for a start
    I2C_ADDR,   // receiving slave address
    I2C_AACK,   // driving address acknowledge
    I2C_INDEX,  // receiving register index
    I2C_WDATA,  // receiving write data
    I2C_WACK,   // driving byte acknowledge
    I2C_RDATA,  // sending read data
    I2C_RACK    // sampling master acknowledge
  } dmcp_i2c_e;
endpackage
`default_nettype wire

//--- dv/dmcp_host_model.sv
// host model driving the four-wire and two-wire control port
`default_nettype none
module dmcp_host_model (
  output var logic  ctrlSelectN,     // select, or strap lo
  output var logic  ctrlSerialIn,    // data in, or strap hi
  output var logic  ctrlBitClock,    // bit clock, or bus clock
  output wire logic ctrlSerialOutIn, // resolved bus data wire
  input  wire logic ctrlSerialOut,   // device data out
  input  wire logic ctrlSerialOutEn  // device output enable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sdaDrv = 1'b1;  // master data, high means released
  int   qtr    = 625;   // quarter bus period in ns

  // open drain with pull-up: low if either side pulls
  assign ctrlSerialOutIn = sdaDrv & ~(ctrlSerialOutEn & ~ctrlSerialOut);

  // idle: select high, bit clock parked low between frames
  initial begin
    ctrlSelectN  = 1'b1;
    ctrlSerialIn = 1'b0;
    ctrlBitClock = 1'b0;
  end

  // one word of n pulses; readback sampled on rises 9..16
  task automatic spiWord(input logic [15:0] w, input int n,
                         output logic [7:0] rd);
    rd = 8'h00;
    #13 ctrlSelectN = 1'b0;
    #40;
    for (int i = 15; i > 15 - n; i--) begin
      ctrlSerialIn = w[i];
      #80 ctrlBitClock = 1'b1;
      if (i < 8)
        rd[i] = ctrlSerialOut;
      #80 ctrlBitClock = 1'b0;
    end
    #40 ctrlSelectN = 1'b1;
    // released data line shows the inverse, not a stale bit
    ctrlSerialIn = ~ctrlSerialIn;
    #200;
  endtask

  // two-wire mode: straps on select and data, bus clock idles high
  task automatic straps(input logic [1:0] s);
    ctrlSelectN  = s[0];
    ctrlSerialIn = s[1];
    ctrlBitClock = 1'b1;
  endtask

  // start, also usable as repeated start
  task automatic i2cStart();
    sdaDrv = 1'b1;
    #(qtr + 7) ctrlBitClock = 1'b1;
    #qtr sdaDrv = 1'b0;
    #qtr ctrlBitClock = 1'b0;
    #qtr;
  endtask

  task automatic i2cStop();
    sdaDrv = 1'b0;
    #qtr ctrlBitClock = 1'b1;
    #qtr sdaDrv = 1'b1;
    #qtr;
  endtask

  // one bus bit: drive b, return the wire level at mid-high
  task automatic i2cBit(input logic b, output logic s);
    sdaDrv = b;
    #qtr ctrlBitClock = 1'b1;
    #qtr s = ctrlSerialOutIn;
    #qtr ctrlBitClock = 1'b0;
    #qtr;
  endtask

  // byte msb first plus acknowledge slot
  task automatic i2cByte(input logic [7:0] tx, input logic ackIn,
                         output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
      i2cBit(tx[i], rx[i]);
    i2cBit(ackIn, ack);
  endtask
endmodule
`default_nettype wire

//--- dv/dmcp_control_port_tb.sv
// self-checking bench for the mode control port
`default_nettype none
module dmcp_control_port_tb;
  import dmcp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clk = 1'b0;     // system clock
  logic                   reset = 1'b1;   // async reset
  logic                   portTypeSelect = 1'b0; // low four-wire
  wire logic              selN;           // select or strap lo
  wire logic              sdi;            // data in or strap hi
  wire logic              bclk;           // bit clock or bus clock
  wire logic              sdaIn;          // resolved bus data
  wire logic              sdo;            // device data out
  wire logic              sdoEn;          // device output enable
  wire logic [REG_COUNT*8-1:0] modeRegs;  // register contents
  logic [7:0]             expReg [REG_COUNT]; // expected registers
  logic [31:0]            seed = 32'h0000_8556; // random state
  logic [1:0]             strap = 2'h0;   // address straps
  int                     failures = 0;
  int                     nTests = 0;

  dmcp_control_port u_dut (
    .clk(clk), .reset(reset), .portTypeSelect(portTypeSelect),
    .ctrlSelectN(selN), .ctrlSerialIn(sdi), .ctrlBitClock(bclk),
    .ctrlSerialOutIn(sdaIn), .ctrlSerialOut(sdo),
    .ctrlSerialOutEn(sdoEn), .modeRegs(modeRegs));

  dmcp_host_model u_host (
    .ctrlSelectN(selN), .ctrlSerialIn(sdi), .ctrlBitClock(bclk),
    .ctrlSerialOutIn(sdaIn), .ctrlSerialOut(sdo),
    .ctrlSerialOutEn(sdoEn));

  // 25 MHz system clock
  always #20 clk = ~clk;

  // ****************************************
  // expectation helpers and compares
  // ****************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected bank, slot k in bits 8k+7..8k
  function automatic logic [REG_COUNT*8-1:0] expBank();
    logic [REG_COUNT*8-1:0] b;
    for (int k = 0; k < REG_COUNT; k++)
      b[8*k +: 8] = expReg[k];
    return b;
  endfunction

  function automatic logic [7:0] addrByte(input logic [1:0] s,
                                          input logic rw);
    return {ADDR_PREFIX, s, rw};
  endfunction

  task automatic chk1(input string what, input logic e, input logic g);
    nTests++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic chk8(input string what, input logic [7:0] e,
                      input logic [7:0] g);
    nTests++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chkRegs(input string what);
    nTests++;
    if (modeRegs !== expBank()) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, expBank(), modeRegs);
    end
  endtask

  // bus write of n random bytes from idx, no stop
  task automatic busWrite(input logic [6:0] idx, input int n);
    logic [7:0] rx;
    logic [7:0] d;
    logic       ack;
    u_host.i2cStart();
    u_host.i2cByte(addrByte(strap, 1'b0), 1'b1, rx, ack);
    chk1("addr ack", 1'b0, ack);
    u_host.i2cByte({1'b0, idx}, 1'b1, rx, ack);
    if (n > 0)
      chk1("index ack", 1'b0, ack);
    for (int i = 0; i < n; i++) begin
      d = 8'(rnd());
      u_host.i2cByte(d, 1'b1, rx, ack);
      chk1("data ack", 1'b0, ack);
      expReg[idx - REG_FIRST + i] = d;
    end
  endtask

  // bus read of n bytes expected from idx on, then stop
  task automatic busRead(input logic [6:0] idx, input int n);
    logic [7:0] rx;
    logic       ack;
    u_host.i2cStart();
    u_host.i2cByte(addrByte(strap, 1'b1), 1'b1, rx, ack);
    chk1("read addr ack", 1'b0, ack);
    for (int i = 0; i < n; i++) begin
      u_host.i2cByte(8'hFF, (i == n - 1), rx, ack);
      chk8("bus read", expReg[idx - REG_FIRST + i], rx);
    end
    u_host.i2cStop();
  endtask

  task automatic results();
    $display("tests %0d failures %0d", nTests, failures);
    if (failures == 0 && nTests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // watchdog: whole run needs about 1.4 ms, limit at 2 ms
  initial begin
    #2ms;
    failures++;
    results();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [7:0] rd;
    logic [7:0] rx;
    logic       ack;
    int         j;
    for (int k = 0; k < REG_COUNT; k++)
      expReg[k] = REG_RESET;
    repeat (16) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    chkRegs("reset values");
    chk1("out enable", 1'b1, sdoEn);
    // every defined register gets random data
    for (int k = 0; k < REG_COUNT; k++) begin
      expReg[k] = 8'(rnd());
      u_host.spiWord({1'b0, REG_FIRST + 7'(k), expReg[k]}, 16, rd);
      repeat (8) @(negedge clk);
      chkRegs("spi write");
    end
    // cut word and undefined index must not land
    u_host.spiWord({1'b0, REG_FIRST, ~expReg[0]}, 15, rd);
    u_host.spiWord({1'b0, 7'h05, 8'h5A}, 16, rd);
    repeat (8) @(negedge clk);
    chkRegs("refused write");
    // read back in reverse order, low byte random
    for (int k = REG_COUNT - 1; k >= 0; k--) begin
      u_host.spiWord({1'b1, REG_FIRST + 7'(k), 8'(rnd())}, 16, rd);
      chk8("spi read", expReg[k], rd);
      chk1("idle out", 1'b0, sdo);
    end
    chkRegs("after reads");
    $display("test four-wire done");
    // switch to the two-wire slave with random straps
    strap = 2'(rnd());
    @(negedge clk);
    portTypeSelect = 1'b1;
    repeat (4) @(negedge clk);
    u_host.straps(strap);
    repeat (8) @(negedge clk);
    // foreign addresses are ignored
    for (int a = 1; a < 4; a++) begin
      u_host.i2cStart();
      u_host.i2cByte(addrByte(strap ^ 2'(a), 1'b0), 1'b1, rx, ack);
      u_host.i2cStop();
      chk1("foreign ack", 1'b1, ack);
    end
    // write two, read two across a repeated start; first pass slow
    for (int s = 0; s < 4; s++) begin
      u_host.qtr = (s == 0) ? 2500 : 625;
      j = int'(rnd() % 32'd6);
      busWrite(REG_FIRST + 7'(j), 2);
      busRead(REG_FIRST + 7'(j + 1), 2);
      repeat (8) @(negedge clk);
      chkRegs("bus write");
      chk1("sda free", 1'b0, sdoEn);
    end
    // undefined index write gets no acknowledge
    busWrite(7'h20, 0);
    u_host.i2cByte(8'h5A, 1'b1, rx, ack);
    u_host.i2cStop();
    chk1("undef ack", 1'b1, ack);
    repeat (8) @(negedge clk);
    chkRegs("undef write");
    $display("test two-wire done");
    results();
  end
endmodule
`default_nettype wire
